// File: logic/phy_boot_and_mii_sequencing.sv
`timescale 1ns/100ps
`include "phy_seq_defs.svh"
module phy_boot_and_mii_sequencing
  import phy_seq_pkg::*;
#(
  parameter int unsigned BOOT_DONE_CYCLES = `BOOT_DONE_CYC,
  parameter logic [4:0] PHY_ADDR = `PHY_ADDR_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // mii transmit side
  input wire logic tx_en,
  output logic crs,
  output logic line_tx_en,
  // mii receive side
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd,
  // line receiver
  input wire logic line_rx_active,
  input wire logic line_rx_err,
  input wire logic [3:0] line_rxd,
  // management
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  output logic mgmt_interrupt_pin_out,
  output logic mgmt_interrupt_pin_oe_n,
  // general-purpose / strap pins
  input wire logic gp_pin_zero_in,
  output logic gp_pin_zero_out,
  output logic gp_pin_zero_oe_n,
  input wire logic gp_pin_one_in,
  output logic gp_pin_one_out,
  output logic gp_pin_one_oe_n
);
  localparam int TX_DLY = `CRS_LAT_CYC - `SYNC_STAGES;
  // pin enters the synchroniser two edges before the strap load, so wait those out
  localparam logic [`BOOT_CNT_W-1:0] T_STRAP = `BOOT_CNT_W'(`STRAP_CYC + `SYNC_STAGES);
  localparam logic [`BOOT_CNT_W-1:0] T_DONE = `BOOT_CNT_W'(BOOT_DONE_CYCLES);
  localparam logic [`BOOT_CNT_W-1:0] T_PULSE_END = `BOOT_CNT_W'(BOOT_DONE_CYCLES + `INT_PULSE_CYC);
  localparam logic [`BOOT_CNT_W-1:0] T_HANDOVER = `BOOT_CNT_W'(BOOT_DONE_CYCLES + `GRACE_CYC);
  localparam logic [`RXM_AW-1:0] RX_K = `RXM_AW'(`RX_LAT_CYC);

  function automatic logic [1:0] pin_drive(input pin_fn_t fn, input logic clk_ph);
    logic [1:0] v;
    v = `PIN_RELEASED;
    unique case (fn)
      PF_INPUT: v = `PIN_RELEASED;
      PF_CLOCK: v = {1'b0, clk_ph};
      PF_LOW: v = {1'b0, 1'b0};
      PF_HIGH: v = {1'b0, 1'b1};
    endcase
    return v;
  endfunction

  // pin synchronisers: tx_en, mdc, mdio, gp0, gp1
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {gp_pin_one_in, gp_pin_zero_in, mdio_in, mdc, tx_en};
      pin_sync <= pin_meta;
    end
  end
  wire tx_s = pin_sync[0];
  wire mdc_s = pin_sync[1];
  wire mdio_s = pin_sync[2];
  wire gp0_s = pin_sync[3];
  wire gp1_s = pin_sync[4];

  // control state
  logic soft_rst;
  logic link_en;
  logic iso;
  logic strap0;
  logic strap1;
  pin_fn_t fn0;
  pin_fn_t fn1;
  logic clk25;

  // boot sequencing
  logic [`BOOT_CNT_W-1:0] boot_cnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_cnt <= '0;
    end else if (soft_rst) begin
      boot_cnt <= '0;
    end else if (boot_cnt != T_HANDOVER) begin
      boot_cnt <= `BOOT_CNT_W'(boot_cnt + 1'b1);
    end
  end
  wire strap_take = boot_cnt == T_STRAP;
  wire int_low = (boot_cnt >= T_DONE) && (boot_cnt < T_PULSE_END);
  wire boot_done = boot_cnt == T_HANDOVER;
  wire comm_en = boot_done && link_en && !iso;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mgmt_interrupt_pin_oe_n <= 1'b1;
    end else begin
      mgmt_interrupt_pin_oe_n <= !int_low;
    end
  end
  // open drain: only ever pulls low
  assign mgmt_interrupt_pin_out = 1'b0;

  // management frame receiver
  mdio_state_t mstate;
  logic [3:0] mcnt;
  logic [12:0] hdr;
  logic [15:0] sh;
  logic op_rd;
  logic hit;
  logic [4:0] reg_addr;
  logic mdc_q;
  logic wr_fire;
  logic [4:0] wr_reg;
  logic [15:0] wr_data;

  wire mdc_rise = mdc_s && !mdc_q;
  wire [12:0] hdr_full = {hdr[11:0], mdio_s};
  wire [1:0] hdr_op = hdr_full[11:10];
  wire hdr_ok = hdr_full[12] && (hdr_full[9:5] == PHY_ADDR);
  wire hdr_rd = hdr_op == `MDIO_OP_RD;
  wire hdr_wr = hdr_op == `MDIO_OP_WR;
  wire [15:0] sh_full = {sh[14:0], mdio_s};

  logic [15:0] ctrl_rd;
  logic [15:0] pcfg_rd;
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[`CTRL_LINK_BIT] = link_en;
    ctrl_rd[`CTRL_ISO_BIT] = iso;
    pcfg_rd = '0;
    pcfg_rd[`PCFG_GP0_LSB +: 2] = fn0;
    pcfg_rd[`PCFG_GP1_LSB +: 2] = fn1;
    pcfg_rd[`PCFG_STRAP0_BIT] = strap0;
    pcfg_rd[`PCFG_STRAP1_BIT] = strap1;
  end
  wire sel_ctrl = reg_addr == `REG_BASIC_CTRL;
  wire sel_pcfg = reg_addr == `REG_PIN_CFG;
  // unmapped addresses read as zero
  wire [15:0] rd_word = sel_ctrl ? ctrl_rd : (sel_pcfg ? pcfg_rd : 16'h0000);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mstate <= M_IDLE;
      mcnt <= '0;
      hdr <= '0;
      sh <= '0;
      op_rd <= 1'b0;
      hit <= 1'b0;
      reg_addr <= '0;
      mdc_q <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
      wr_fire <= 1'b0;
      wr_reg <= '0;
      wr_data <= '0;
    end else begin
      mdc_q <= mdc_s;
      wr_fire <= 1'b0;
      if (mdc_rise) begin
        unique case (mstate)
          M_IDLE: begin
            if (!mdio_s) begin
              mstate <= M_HDR;
              mcnt <= '0;
            end
          end
          M_HDR: begin
            hdr <= hdr_full;
            mcnt <= mcnt + 4'h1;
            if (mcnt == `MDIO_HDR_LAST) begin
              mstate <= M_TA;
              mcnt <= '0;
              op_rd <= hdr_rd;
              hit <= hdr_ok && (hdr_rd || hdr_wr);
              reg_addr <= hdr_full[4:0];
            end
          end
          M_TA: begin
            mcnt <= mcnt + 4'h1;
            if (hit && op_rd) begin
              mdio_oe_n <= 1'b0;
              mdio_out <= 1'b0;
            end
            if (mcnt == `MDIO_TA_LAST) begin
              mstate <= M_DATA;
              mcnt <= '0;
              if (hit && op_rd) begin
                mdio_out <= rd_word[15];
                sh <= {rd_word[14:0], 1'b0};
              end
            end
          end
          M_DATA: begin
            mcnt <= mcnt + 4'h1;
            if (op_rd) begin
              mdio_out <= sh[15];
              sh <= {sh[14:0], 1'b0};
            end else begin
              sh <= sh_full;
            end
            if (mcnt == `MDIO_DATA_LAST) begin
              mstate <= M_IDLE;
              mdio_oe_n <= 1'b1;
              mdio_out <= 1'b1;
              wr_fire <= hit && !op_rd;
              wr_reg <= reg_addr;
              wr_data <= sh_full;
            end
          end
        endcase
      end
    end
  end

  wire wr_ctrl = wr_fire && (wr_reg == `REG_BASIC_CTRL);
  wire wr_pcfg = wr_fire && (wr_reg == `REG_PIN_CFG);

  // register file; a soft reset restarts boot and reloads defaults
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      soft_rst <= 1'b0;
      link_en <= 1'b0;
      iso <= 1'b1;
      strap0 <= 1'b0;
      strap1 <= 1'b0;
      fn0 <= PF_INPUT;
      fn1 <= PF_INPUT;
    end else begin
      soft_rst <= wr_ctrl && wr_data[`CTRL_RESET_BIT];
      if (soft_rst) begin
        link_en <= 1'b0;
        iso <= 1'b1;
        fn0 <= PF_INPUT;
        fn1 <= PF_INPUT;
      end else if (strap_take) begin
        strap0 <= gp0_s;
        strap1 <= gp1_s;
        iso <= gp0_s;
      end else if (wr_ctrl && !wr_data[`CTRL_RESET_BIT]) begin
        link_en <= wr_data[`CTRL_LINK_BIT];
        iso <= wr_data[`CTRL_ISO_BIT];
      end else if (wr_pcfg) begin
        fn0 <= pin_fn_t'(wr_data[`PCFG_GP0_LSB +: 2]);
        fn1 <= pin_fn_t'(wr_data[`PCFG_GP1_LSB +: 2]);
      end
    end
  end

  // general-purpose pins: released until handover, then per configuration
  // half-rate toggle of the 50 MHz core clock, itself locked to the reference
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk25 <= 1'b0;
      {gp_pin_zero_oe_n, gp_pin_zero_out} <= `PIN_RELEASED;
      {gp_pin_one_oe_n, gp_pin_one_out} <= `PIN_RELEASED;
    end else begin
      clk25 <= !clk25;
      {gp_pin_zero_oe_n, gp_pin_zero_out} <= boot_done ? pin_drive(fn0, clk25) : `PIN_RELEASED;
      {gp_pin_one_oe_n, gp_pin_one_out} <= boot_done ? pin_drive(fn1, clk25) : `PIN_RELEASED;
    end
  end

  // transmit enable to carrier sense: fixed pipeline, equal on both edges
  logic [TX_DLY-1:0] tx_pipe;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_pipe <= '0;
      crs <= 1'b0;
      line_tx_en <= 1'b0;
    end else begin
      tx_pipe <= {tx_pipe[TX_DLY-2:0], tx_s};
      crs <= comm_en && (tx_pipe[TX_DLY-1] || line_rx_active);
      line_tx_en <= comm_en && tx_s;
    end
  end

  // receive path delayed through a ring buffer
  rx_delay_if rxm ();
  logic [`RXM_AW-1:0] wptr;
  logic primed;
  rx_word_t rx_in;
  assign rx_in = comm_en ? rx_word_t'{dv: line_rx_active, er: line_rx_err, d: line_rxd} : '0;
  assign rxm.wr_en = 1'b1;
  assign rxm.wr_addr = wptr;
  assign rxm.wr_data = rx_in;
  assign rxm.rd_addr = `RXM_AW'(wptr - RX_K);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      primed <= 1'b0;
    end else begin
      wptr <= `RXM_AW'(wptr + 1'b1);
      // unwritten cells hold junk until the ring has passed the read point once
      if (wptr == RX_K) begin
        primed <= 1'b1;
      end
    end
  end

  rx_delay_mem u_rx_delay_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .port(rxm.mem)
  );

  assign rx_dv = primed ? rxm.rd_data.dv : 1'b0;
  assign rx_er = primed ? rxm.rd_data.er : 1'b0;
  assign rxd = primed ? rxm.rd_data.d : 4'h0;
endmodule // phy_boot_and_mii_sequencing

// File: logic/phy_seq_defs.svh
`ifndef PHY_SEQ_DEFS_SVH
`define PHY_SEQ_DEFS_SVH
// Overview of operation
// - carrier sense rises 800 ns after the mac raises transmit enable
// - carrier sense falls 800 ns after the mac drops transmit enable
// - receive data, error and valid appear 6.4 us after carrier sense asserts
// - straps are sampled between 2 us and 16 us after reset release
// - boot done drives the interrupt pin low 0.5 to 2 ms after release, 160-320 ns
// - strap pins are driven no sooner than 640 ns after boot done asserts
// - each general-purpose pin can output the 25 MHz clock via pin configuration
// - after any reset, traffic is held off until software enables operation
// - writing one to control bit 15 resets the device
// - writing zero to control bit 10 leaves the isolated boot state
// - setting control bit 13 enables the link
// - registers are reached over the mdc/mdio management interface

// clock
`define CLK_PERIOD_NS 20
`define SYNC_STAGES 2

// mii latencies
`define CRS_LAT_NS 800
`define CRS_LAT_CYC (`CRS_LAT_NS / `CLK_PERIOD_NS)
`define RX_LAT_NS 6400
`define RX_LAT_CYC (`RX_LAT_NS / `CLK_PERIOD_NS)
`define RXM_AW 9

// boot timing
`define STRAP_MIN_NS 2000
`define STRAP_CYC ((`STRAP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_DONE_NS 1500000
`define BOOT_DONE_CYC (`BOOT_DONE_NS / `CLK_PERIOD_NS)
`define INT_PULSE_NS 240
`define INT_PULSE_CYC ((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GRACE_NS 640
`define GRACE_CYC ((`GRACE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_CNT_W 18

// register map
`define REG_BASIC_CTRL 5'h00
`define REG_PIN_CFG 5'h12
`define CTRL_RESET_BIT 15
`define CTRL_LINK_BIT 13
`define CTRL_ISO_BIT 10
`define PCFG_GP0_LSB 0
`define PCFG_GP1_LSB 2
`define PCFG_STRAP0_BIT 14
`define PCFG_STRAP1_BIT 15
`define PHY_ADDR_DEFAULT 5'h00

// management frame
`define MDIO_OP_RD 2'h2
`define MDIO_OP_WR 2'h1
`define MDIO_HDR_LAST 4'hc
`define MDIO_TA_LAST 4'h1
`define MDIO_DATA_LAST 4'hf

// pin drive pair {oe_n, out}
`define PIN_RELEASED 2'h2
`endif

// File: logic/phy_seq_pkg.sv
`include "phy_seq_defs.svh"
package phy_seq_pkg;
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_HDR = 2'h1,
    M_TA = 2'h2,
    M_DATA = 2'h3
  } mdio_state_t;

  typedef enum logic [1:0] {
    PF_INPUT = 2'h0,
    PF_CLOCK = 2'h1,
    PF_LOW = 2'h2,
    PF_HIGH = 2'h3
  } pin_fn_t;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } rx_word_t;
endpackage

// File: logic/rx_delay_if.sv
`timescale 1ns/100ps
`include "phy_seq_defs.svh"
interface rx_delay_if;
  import phy_seq_pkg::*;
  logic wr_en;
  logic [`RXM_AW-1:0] wr_addr;
  logic [`RXM_AW-1:0] rd_addr;
  rx_word_t wr_data;
  rx_word_t rd_data;
  modport owner (output wr_en, output wr_addr, output rd_addr, output wr_data, input rd_data);
  modport mem (input wr_en, input wr_addr, input rd_addr, input wr_data, output rd_data);
endinterface

// File: logic/rx_delay_mem.sv
`timescale 1ns/100ps
`include "phy_seq_defs.svh"
module rx_delay_mem
  import phy_seq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // storage port
  rx_delay_if.mem port
);
  rx_word_t store [2**`RXM_AW];

  // ram cells carry no reset so the array maps to block memory
  always_ff @(posedge clk_sys) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port.rd_data <= '0;
    end else begin
      port.rd_data <= store[port.rd_addr];
    end
  end
endmodule // rx_delay_mem

// File: testbench/phy_seq_asserts.sv
`timescale 1ns/100ps
module phy_seq_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // mii
  input wire logic tx_en,
  input wire logic crs,
  input wire logic line_tx_en,
  input wire logic rx_dv,
  input wire logic [3:0] rxd,
  input wire logic line_rx_active,
  input wire logic [3:0] line_rxd,
  // management and straps
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic mgmt_interrupt_pin_oe_n,
  input wire logic gp_pin_zero_oe_n,
  input wire logic gp_pin_one_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [5:0] grace;
  // saturates so a long run never wraps back under the limit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      grace <= 6'h0;
    end else if ($fell(mgmt_interrupt_pin_oe_n)) begin
      grace <= 6'h1;
    end else if (grace != 6'h0 && grace != 6'h3f) begin
      grace <= grace + 6'h1;
    end
  end
  sequence int_low_twelve;
    !mgmt_interrupt_pin_oe_n [*8] ##1 !mgmt_interrupt_pin_oe_n [*4];
  endsequence
  a_int_pulse_len: assert property ($fell(mgmt_interrupt_pin_oe_n) |-> int_low_twelve ##1 mgmt_interrupt_pin_oe_n)
    else $error("boot done pulse length wrong");
  a_strap_grace: assert property (!(gp_pin_zero_oe_n && gp_pin_one_oe_n) |-> grace >= 6'h20)
    else $error("strap pin driven too early");
  a_crs_rise_lat: assert property ($rose(line_tx_en) |-> ##38 crs)
    else $error("carrier sense late on rise");
  a_crs_fall_lat: assert property ($fell(line_tx_en) && !line_rx_active |-> ##38 (!crs || $past(line_rx_active)))
    else $error("carrier sense late on fall");
  a_tx_gate_src: assert property ($rose(line_tx_en) |-> $past(tx_en, 2))
    else $error("line transmit without request");
  a_rx_after_crs: assert property ($rose(rx_dv) |-> $past(crs, 319))
    else $error("receive valid not 6.4 us after carrier");
  a_rx_data_lat: assert property (rx_dv |-> rxd == $past(line_rxd, 321))
    else $error("receive nibble delay wrong");
  a_mdio_ta_zero: assert property ($fell(mdio_oe_n) |-> !mdio_out)
    else $error("turnaround bit not zero");
endmodule // phy_seq_asserts
bind phy_boot_and_mii_sequencing phy_seq_asserts u_phy_seq_asserts (.clk_sys, .rst, .tx_en, .crs, .line_tx_en,
  .rx_dv, .rxd, .line_rx_active, .line_rxd, .mdio_out, .mdio_oe_n, .mgmt_interrupt_pin_oe_n, .gp_pin_zero_oe_n,
  .gp_pin_one_oe_n);

// File: testbench/mac_mgmt_model.sv
`timescale 1ns/100ps
module mac_mgmt_model (
  // clock
  input wire logic clk_sys,
  // management master
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_drv_oe_n,
  input wire logic mdio_line,
  // mii transmit
  output logic tx_en
);
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_drv_oe_n = 1'b1;
    tx_en = 1'b0;
  end
  // data moves only with mdc low; read bits taken just before the rise
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd, input int hp, output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'h1, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      @(negedge clk_sys);
      mdc = 1'b0;
      mdio_drv_oe_n = op == 2'h2 && i >= 14;
      mdio_drv = bits[31 - i];
      repeat (hp) @(negedge clk_sys);
      if (i >= 16) rd = {rd[14:0], mdio_line};
      mdc = 1'b1;
      repeat (hp - 1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    mdc = 1'b0;
    mdio_drv_oe_n = 1'b1;
  endtask
  task automatic transmit(input int len);
    @(negedge clk_sys);
    tx_en = 1'b1;
    repeat (len) @(negedge clk_sys);
    tx_en = 1'b0;
  endtask
endmodule // mac_mgmt_model

// File: testbench/phy_boot_and_mii_sequencing_bench.sv
`timescale 1ns/100ps
module phy_boot_and_mii_sequencing_bench;
  import phy_seq_pkg::*;
  localparam int BOOT = 200;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic crs, line_tx_en, rx_dv, rx_er, mdio_out, mdio_oe_n, mgmt_interrupt_pin_oe_n, int_out;
  logic [3:0] rxd;
  logic line_rx_active = 1'b0;
  logic line_rx_err = 1'b0;
  logic [3:0] line_rxd = 4'h0;
  logic mdc, m_drv, m_oe_n, tx_en, mdio_line;
  logic gp_pin_zero_out, gp_pin_zero_oe_n, gp_pin_one_out, gp_pin_one_oe_n;
  logic strap_on = 1'b1;
  logic strap_v = 1'b0;
  logic rx_chk = 1'b0;
  logic [15:0] lfsr = 16'h0021;
  logic [15:0] reg_m [int];
  rx_word_t hist [int];
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  // pull-up on mdio; released straps float, so they carry noise
  assign mdio_line = !mdio_oe_n ? mdio_out : (!m_oe_n ? m_drv : 1'b1);
  wire gp0 = !gp_pin_zero_oe_n ? gp_pin_zero_out : (strap_on ? strap_v : lfsr[0]);
  wire gp1 = !gp_pin_one_oe_n ? gp_pin_one_out : (strap_on ? 1'b0 : lfsr[1]);
  phy_boot_and_mii_sequencing #(.BOOT_DONE_CYCLES(BOOT)) u_phy_boot_and_mii_sequencing (.clk_sys, .rst, .tx_en,
    .crs, .line_tx_en, .rx_dv, .rx_er, .rxd, .line_rx_active, .line_rx_err, .line_rxd, .mdc, .mdio_in(mdio_line),
    .mdio_out, .mdio_oe_n, .mgmt_interrupt_pin_out(int_out), .mgmt_interrupt_pin_oe_n, .gp_pin_zero_in(gp0),
    .gp_pin_zero_out, .gp_pin_zero_oe_n, .gp_pin_one_in(gp1), .gp_pin_one_out, .gp_pin_one_oe_n);
  mac_mgmt_model u_mac_mgmt_model (.clk_sys, .mdc, .mdio_drv(m_drv), .mdio_drv_oe_n(m_oe_n), .mdio_line, .tx_en);
  always #10 clk_sys = ~clk_sys;
  function automatic logic [15:0] next_lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic print_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    fails++;
    $display("mismatch t=%0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) bad($sformatf("value %h expected %h", got, exp));
  endtask
  task automatic chk_cnt(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) bad($sformatf("count %0d outside %0d..%0d", got, lo, hi));
  endtask
  task automatic chk_rx(input rx_word_t got, input rx_word_t exp);
    compares++;
    if (got !== exp) bad($sformatf("rx word %h expected %h", got, exp));
  endtask
  always @(posedge clk_sys) begin
    hist[cyc] = {line_rx_active, line_rx_err, line_rxd};
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad("timeout");
      print_verdict();
    end
  end
  always @(negedge clk_sys) begin
    lfsr <= next_lfsr(lfsr);
    if (rx_chk) chk_rx({rx_dv, rx_er, rxd}, hist[cyc - 321]);
  end
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    u_mac_mgmt_model.frame(2'h1, 5'h00, ra, wd, 3 + lfsr[1:0], d);
    if (ra == 5'h00) reg_m[0] = wd[15] ? 16'h0400 : wd & 16'h2400;
    if (ra == 5'h00 && wd[15]) reg_m[18] = 16'h4000;
    if (ra == 5'h12) reg_m[18] = (wd & 16'h000f) | 16'h4000;
  endtask
  task automatic rd_chk(input logic [4:0] ra);
    logic [15:0] d;
    u_mac_mgmt_model.frame(2'h2, 5'h00, ra, 16'h0000, 3 + lfsr[2:1], d);
    chk_reg(d, reg_m.exists(ra) ? reg_m[ra] : 16'h0000);
  endtask
  task automatic wait_boot(output int n, output int w);
    n = 0;
    w = 0;
    while (mgmt_interrupt_pin_oe_n !== 1'b0 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    // pulled-up pin level must read low during the pulse
    chk_reg({15'h0000, mgmt_interrupt_pin_oe_n | int_out}, 16'h0000);
    strap_on = 1'b0;
    while (mgmt_interrupt_pin_oe_n === 1'b0 && w < 100) begin
      @(negedge clk_sys);
      w++;
    end
  endtask
  task automatic tx_meas(input int len, output int r, output int f);
    r = 0;
    f = 0;
    fork
      u_mac_mgmt_model.transmit(len);
      begin
        wait (tx_en === 1'b1);
        // bounded by length: reading tx_en here would race its own release
        while (crs !== 1'b1 && r < len) begin
          @(negedge clk_sys);
          r++;
        end
        wait (tx_en === 1'b0);
        while (crs !== 1'b0 && f < 99) begin
          @(negedge clk_sys);
          f++;
        end
      end
    join
  endtask
  initial begin
    int n, w, r, f;
    logic p0, p1;
    logic [15:0] d;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    // a strap settling just before 2 us must still be the value taken
    repeat (99) @(negedge clk_sys);
    strap_v = 1'b1;
    wait_boot(n, w);
    chk_cnt(n + 99, BOOT, BOOT + 2);
    chk_cnt(w, 8, 16);
    reg_m[0] = 16'h0400;
    reg_m[18] = 16'h4000;
    rd_chk(5'h00);
    rd_chk(5'h12);
    tx_meas(60, r, f);
    chk_cnt(r, 60, 60);
    wr(5'h00, 16'h8000);
    strap_on = 1'b1;
    wait_boot(n, w);
    chk_cnt(n, BOOT - 8, BOOT + 8);
    chk_cnt(w, 8, 16);
    rd_chk(5'h00);
    wr(5'h00, 16'h0000);
    rd_chk(5'h00);
    wr(5'h00, 16'h2000);
    rd_chk(5'h00);
    rd_chk(5'h05);
    u_mac_mgmt_model.frame(2'h2, 5'h01, 5'h00, 16'h0000, 4, d);
    chk_reg(d, 16'hffff);
    for (int fn = 0; fn < 4; fn++) begin
      wr(5'h12, {2'h3, 10'h000, fn[1:0], fn[1:0]});
      rd_chk(5'h12);
      p0 = gp_pin_zero_out;
      p1 = gp_pin_one_out;
      @(negedge clk_sys);
      chk_reg({gp_pin_zero_oe_n, gp_pin_zero_out & !gp_pin_zero_oe_n}, {fn == 0, fn == 1 ? !p0 : fn == 3});
      chk_reg({gp_pin_one_oe_n, gp_pin_one_out & !gp_pin_one_oe_n}, {fn == 0, fn == 1 ? !p1 : fn == 3});
    end
    for (int i = 0; i < 3; i++) begin
      tx_meas(50 + lfsr[5:0], r, f);
      // pin moves half a cycle before its sampling edge, the look is half a cycle after
      chk_cnt(r, 41, 41);
      chk_cnt(f, 41, 41);
    end
    rx_chk = 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge clk_sys);
      line_rx_active = 1'b1;
      line_rxd = lfsr[3:0];
      line_rx_err = lfsr[7] & lfsr[9];
    end
    @(negedge clk_sys);
    line_rx_active = 1'b0;
    line_rxd = 4'h0;
    line_rx_err = 1'b0;
    repeat (340) @(negedge clk_sys);
    rx_chk = 1'b0;
    print_verdict();
  end
endmodule // phy_boot_and_mii_sequencing_bench
